// File: rtl/timer_pkg.sv
// Shared constants for the 16-bit timer/counter block
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] COUNT_LOW_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] COUNT_HIGH_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'hC;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam int ON_BIT = 0;
  localparam int SOURCE_BIT = 1;
  localparam int SYNC_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int PS_LSB = 4;
  localparam int PS_W = 2;
  localparam logic [CTRL_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [CTRL_W-1:0] CONTROL_WMASK = 8'h3F;
  localparam int OVERFLOW_BIT = 0;

  // ----------------------------------------------------------------
  // Counter, prescaler and timing
  // ----------------------------------------------------------------
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam int PRESC_W = 3;
  localparam int CLOCK_HZ = 40_000_000;
  localparam int INSTR_DIV = 4;
  localparam int INSTR_HZ = CLOCK_HZ / INSTR_DIV;
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(INSTR_DIV - 1);

  // ----------------------------------------------------------------
  // Bus answer state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

// File: rtl/input_prescaler.sv
// Count source edge detector, falling-edge arming and ripple prescaler
`timescale 1ns/10ps
`default_nettype none
module input_prescaler
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic count_input,
  input wire logic internal_tick,
  input wire logic external_mode,
  input wire logic counter_on,
  input wire logic clear_prescaler,
  input wire logic [PS_W-1:0] prescale_select,
  output logic tick
);

  typedef struct packed {
    logic last_level;
    logic armed;
    logic [PRESC_W-1:0] presc;
    logic tick;
  } presc_state_t;

  presc_state_t s_q;
  presc_state_t s_d;
  logic src_event;
  logic [PRESC_W-1:0] limit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Prescaler ignores sleep, so external edges keep being divided there
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // Held low while off, so a source switch at enable cannot fake a falling edge
    s_d.last_level = counter_on && external_mode && count_input;
    limit = PRESC_W'((1 << prescale_select) - 1);
    // Rising edge counts only once a falling edge was seen since enable
    src_event = external_mode ? (count_input && !s_q.last_level && s_q.armed)
                              : internal_tick;
    if (!counter_on || !external_mode) begin
      s_d.armed = 1'b0;
    end else if (!count_input && s_q.last_level) begin
      s_d.armed = 1'b1;
    end
    if (clear_prescaler) begin
      s_d.presc = '0;
    end else if (src_event && counter_on) begin
      if (s_q.presc >= limit) begin
        s_d.presc = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.presc = s_q.presc + PRESC_W'(1);
      end
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (clock_enable) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_presc_clear;
    @(posedge clock) disable iff (rst || !clock_enable)
      clear_prescaler |=> (s_q.presc == '0) && !s_q.tick;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_arm_first;
    @(posedge clock) disable iff (rst || !clock_enable)
      $rose(counter_on) && external_mode |=> !s_q.armed;
  endproperty
  a_arm_first: assert property (p_arm_first) else $error("armed without falling edge");

endmodule
`default_nettype wire

// File: rtl/timer_counter.sv
// 16-bit timer/counter with Avalon-MM register slave
//
// How it works
// - Source select clear: count the instruction clock, a quarter of clock.
// - In timer mode the sync bypass bit is ignored.
// - Counter on bit set lets the count advance; clear holds it.
// - Counter mode counts rising edges, only after a falling edge since enable.
// - Counter mode input is crystal pin if oscillator enabled, else external pin.
// - Sync bypass clear: prescaler output passes a synchroniser; prescaler is ripple.
// - Synchronised counter mode in sleep: count frozen, prescaler keeps dividing.
// - Sync bypass set: no synchroniser, runs in sleep, overflow can wake.
// - Asynchronous counting is not a valid capture/compare time base.
// - Count byte reads return a stable value captured by hardware.
// - Oscillator enable starts the crystal amplifier; sleep never stops it.
// - Any write to a count byte clears the prescaler.
// - Special event clears the count, no overflow flag, except asynchronous mode.
// - A count write beats a coinciding special event clear.
// - Control resets to zero on power-on reset; count bytes never reset.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module timer_counter
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [DATA_W/8-1:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic sleep_mode,
  input wire logic special_event,
  input wire logic crystal_input_pin,
  input wire logic ext_count_input_pin,
  output logic lp_osc_enable,
  output logic overflow_flag,
  output logic wake_request,
  output logic timebase_valid,
  output logic [COUNT_W-1:0] count_value
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match for a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] control;
    logic [PHASE_W-1:0] phase;
    logic sync_stage1;
    logic sync_stage2;
    logic overflow;
    logic wake;
    logic timebase_ok;
    bus_state_t bus_state;
    logic waitreq;
    logic [BYTE_W-1:0] rdata;
    logic [1:0] loaded;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;

  logic counter_on;
  logic ext_mode;
  logic sync_bypass;
  logic async_mode;
  logic [PS_W-1:0] prescale_select;
  logic count_input;
  logic internal_tick;
  logic presc_tick;
  logic inc;
  logic ovf_event;
  logic be_low;
  logic accept_wr;
  logic wr_control;
  logic wr_low;
  logic wr_high;
  logic wr_status;
  logic count_written;
  logic [BYTE_W-1:0] wbyte;
  logic [BYTE_W-1:0] rmux;

  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  // Asynchronous mode needs both the external source and the bypass bit
  assign counter_on = s_q.control[ON_BIT];
  assign ext_mode = s_q.control[SOURCE_BIT];
  assign sync_bypass = s_q.control[SYNC_BIT];
  assign async_mode = ext_mode && sync_bypass;
  assign prescale_select = s_q.control[PS_LSB +: PS_W];

  // Crystal pin takes over as count input while the oscillator runs
  assign count_input = s_q.control[OSC_BIT] ? crystal_input_pin : ext_count_input_pin;

  // Instruction clock: one pulse every fourth clock, stopped in sleep
  assign internal_tick = (s_q.phase == PHASE_LAST) && !sleep_mode;

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  // Writes land only at the edge where waitrequest is seen low
  assign be_low = byteenable[0];
  assign accept_wr = (s_q.bus_state == BUS_ANSWER) && write && be_low;
  assign wr_control = accept_wr && hit(address, CONTROL_OFS);
  assign wr_low = accept_wr && hit(address, COUNT_LOW_OFS);
  assign wr_high = accept_wr && hit(address, COUNT_HIGH_OFS);
  assign wr_status = accept_wr && hit(address, STATUS_OFS);
  assign count_written = wr_low || wr_high;
  assign wbyte = writedata[BYTE_W-1:0];

  // ----------------------------------------------------------------
  // Input stage and prescaler
  // ----------------------------------------------------------------
  input_prescaler input_prescaler_inst (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .count_input(count_input),
    .internal_tick(internal_tick),
    .external_mode(ext_mode),
    .counter_on(counter_on),
    .clear_prescaler(count_written),
    .prescale_select(prescale_select),
    .tick(presc_tick)
  );

  // ----------------------------------------------------------------
  // Increment select
  // ----------------------------------------------------------------
  // Timer and asynchronous modes use the prescaler pulse directly; the
  // synchronised path waits two stages and is dead while asleep
  always_comb begin
    if (!counter_on) begin
      inc = 1'b0;
    end else if (!ext_mode) begin
      inc = presc_tick;
    end else if (sync_bypass) begin
      inc = presc_tick;
    end else begin
      inc = s_q.sync_stage2 && !sleep_mode;
    end
  end

  // ----------------------------------------------------------------
  // Counter next value
  // ----------------------------------------------------------------
  // Software write wins over the special event, which wins over counting;
  // a write racing an increment simply drops the increment
  always_comb begin
    count_d = count_q;
    ovf_event = 1'b0;
    if (count_written) begin
      if (wr_low) begin
        count_d[BYTE_W-1:0] = wbyte;
      end
      if (wr_high) begin
        count_d[COUNT_W-1:BYTE_W] = wbyte;
      end
    end else if (special_event && !async_mode) begin
      count_d = '0;
    end else if (inc) begin
      count_d = count_q + COUNT_ONE;
      ovf_event = (count_q == COUNT_MAX);
    end
  end

  // Count bytes survive every reset, so this register has none
  always_ff @(posedge clock) begin
    if (clock_enable) begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // Whole count is a clocked register, so either byte reads stable
  always_comb begin
    rmux = '0;
    if (hit(address, CONTROL_OFS)) begin
      rmux = s_q.control;
    end else if (hit(address, COUNT_LOW_OFS)) begin
      rmux = count_q[BYTE_W-1:0];
    end else if (hit(address, COUNT_HIGH_OFS)) begin
      rmux = count_q[COUNT_W-1:BYTE_W];
    end else if (hit(address, STATUS_OFS)) begin
      rmux[OVERFLOW_BIT] = s_q.overflow;
    end
  end

  // ----------------------------------------------------------------
  // Main next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.phase = sleep_mode ? s_q.phase : s_q.phase + PHASE_W'(1);
    // Synchroniser is switched off in sleep; first stage feeds only the second
    s_d.sync_stage1 = presc_tick && ext_mode && !sync_bypass && !sleep_mode;
    s_d.sync_stage2 = s_q.sync_stage1;
    if (wr_control) begin
      s_d.control = wbyte & CONTROL_WMASK;
    end
    // Hardware set beats a same-cycle write-one clear
    s_d.overflow = ovf_event || (s_q.overflow && !(wr_status && wbyte[OVERFLOW_BIT]));
    s_d.wake = ovf_event && sleep_mode && async_mode;
    s_d.timebase_ok = !async_mode;
    // Count has no reset, so its hold-off and sleep-hold checks wait until both bytes were written
    s_d.loaded = s_q.loaded | {wr_high, wr_low};
    unique case (s_q.bus_state)
      BUS_IDLE: begin
        if (read || write) begin
          s_d.bus_state = BUS_ANSWER;
          s_d.waitreq = 1'b0;
          s_d.rdata = read ? rmux : s_q.rdata;
        end
      end
      BUS_ANSWER: begin
        s_d.bus_state = BUS_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase
  end

  // Control register is cleared only by power-on reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.control <= CONTROL_RESET;
      s_q.phase <= '0;
      s_q.sync_stage1 <= 1'b0;
      s_q.sync_stage2 <= 1'b0;
      s_q.overflow <= 1'b0;
      s_q.wake <= 1'b0;
      s_q.timebase_ok <= 1'b1;
      s_q.bus_state <= BUS_IDLE;
      s_q.waitreq <= 1'b1;
      s_q.rdata <= '0;
      s_q.loaded <= '0;
    end else if (clock_enable) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Oscillator enable follows the control bit and ignores sleep
  assign lp_osc_enable = s_q.control[OSC_BIT];
  assign readdata = {{(DATA_W-BYTE_W){1'b0}}, s_q.rdata};
  assign waitrequest = s_q.waitreq;
  assign overflow_flag = s_q.overflow;
  assign wake_request = s_q.wake;
  assign timebase_valid = s_q.timebase_ok;
  assign count_value = count_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clock_enable);

  property p_wrap;
    inc && !count_written && !(special_event && !async_mode) && count_q == COUNT_MAX
      |=> count_q == '0 && overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not set flag");

  property p_overflow_sticky;
    overflow_flag && !(wr_status && wbyte[OVERFLOW_BIT]) |=> overflow_flag;
  endproperty
  a_overflow_sticky: assert property (p_overflow_sticky) else $error("flag lost");

  property p_hold_off;
    (&s_q.loaded) && !counter_on && !count_written && !special_event |=> $stable(count_q);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while off");

  property p_special;
    special_event && !async_mode && !count_written && !overflow_flag
      |=> count_q == '0 && !overflow_flag;
  endproperty
  a_special: assert property (p_special) else $error("special event clear wrong");

  property p_write_wins;
    count_written && special_event
      |=> (!$past(wr_low) || count_q[BYTE_W-1:0] == $past(wbyte))
      && (!$past(wr_high) || count_q[COUNT_W-1:BYTE_W] == $past(wbyte));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to event");

  property p_sync_sleep;
    (&s_q.loaded) && counter_on && ext_mode && !sync_bypass && sleep_mode
      && !count_written && !special_event |=> $stable(count_q);
  endproperty
  a_sync_sleep: assert property (p_sync_sleep) else $error("sync count moved in sleep");

  property p_wake;
    inc && async_mode && sleep_mode && count_q == COUNT_MAX && !count_written
      |=> wake_request ##1 !wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse on overflow");

  property p_timebase;
    ##1 timebase_valid == !$past(async_mode);
  endproperty
  a_timebase: assert property (p_timebase) else $error("time base valid wrong");

  property p_timer_rate;
    counter_on && !ext_mode && inc |-> s_q.phase == PHASE_LAST || $past(s_q.phase) == PHASE_LAST
      || $past(s_q.phase, 2) == PHASE_LAST || $past(s_q.phase, 3) == PHASE_LAST;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer off instruction clock");

  property p_read_stable;
    s_q.bus_state == BUS_ANSWER |-> !waitrequest ##1 $stable(readdata);
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("read data moved after answer");

  c_wrap: cover property (ovf_event);
  c_special: cover property (special_event && !async_mode && !count_written);
  c_wake: cover property (wake_request);
  c_bus: cover property (accept_wr ##[1:4] s_q.bus_state == BUS_ANSWER && read);

endmodule
`default_nettype wire

// File: sim/count_source.sv
// Far-side model: external clock pin or crystal feeding the count input
`timescale 1ns/10ps
`default_nettype none
module count_source (
  input wire logic clock,
  input wire logic run,
  input wire logic use_crystal,
  output logic crystal_input_pin,
  output logic ext_count_input_pin
);
  logic sel_q = 1'b0;
  logic [1:0] div_q = 2'h0;
  logic noise_q = 1'b0;

  // Selected source toggles every 3 clocks in a frame and stands low between frames
  always @(posedge clock) begin
    noise_q <= !noise_q;
    if (!run) begin
      sel_q <= 1'b0;
      div_q <= 2'h0;
    end
    else if (div_q == 2'h2) begin
      sel_q <= !sel_q;
      div_q <= 2'h0;
    end
    else begin
      div_q <= div_q + 2'h1;
    end
  end

  // Unselected pin carries a pattern changing every clock, so a wrong pick shows up
  assign crystal_input_pin = use_crystal ? sel_q : noise_q;
  assign ext_count_input_pin = use_crystal ? noise_q : sel_q;
endmodule
`default_nettype wire

// File: sim/timer_counter_tb_top.sv
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
module timer_counter_tb_top import timer_pkg::*; ;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [DATA_W/8-1:0] byteenable = '0;
  logic [DATA_W-1:0] readdata;
  logic waitrequest, lp_osc_enable, overflow_flag, wake_request, timebase_valid;
  logic sleep_mode = 1'b0;
  logic special_event = 1'b0;
  logic run = 1'b0;
  logic use_crystal = 1'b0;
  logic crystal_input_pin, ext_count_input_pin, sel_pin;
  logic pin_d = 1'b0;
  logic [COUNT_W-1:0] count_value, v;
  logic [7:0] q;
  int n_fail = 0;
  int checks = 0;
  int edges = 0;
  int wakes = 0;

  // ----------------------------------------------------------------
  // Clock, instances and monitors
  // ----------------------------------------------------------------
  always #12.5 clock = !clock;

  timer_counter timer_counter_inst (.clock, .rst, .clock_enable(1'b1), .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .sleep_mode,
    .special_event, .crystal_input_pin, .ext_count_input_pin, .lp_osc_enable,
    .overflow_flag, .wake_request, .timebase_valid, .count_value);
  count_source count_source_inst (.clock, .run, .use_crystal, .crystal_input_pin,
    .ext_count_input_pin);

  assign sel_pin = use_crystal ? crystal_input_pin : ext_count_input_pin;

  // Rising edges on the selected pin and wake pulses, counted for expectations
  always @(posedge clock) begin
    pin_d <= sel_pin;
    if (sel_pin && !pin_d)
      edges <= edges + 1;
    if (wake_request === 1'b1)
      wakes <= wakes + 1;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end
    else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] r);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= DATA_W'(d);
    byteenable <= be;
    read <= !wr;
    write <= wr;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (waitrequest !== 1'b0 && i < 20);
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_fail++;
      $display("[FAIL] %0t bus answer timed out", $time);
      final_report();
    end
  endtask

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, 4'h1, r);
  endtask

  task automatic rd8(input logic [3:0] a, output logic [7:0] r);
    bus(1'b0, a, 8'h00, 4'h0, r);
  endtask

  // Safe 16-bit read: high, low, high again, retry on mismatch
  task automatic rd16(output logic [15:0] r);
    logic [7:0] h1, l, h2;
    rd8(COUNT_HIGH_OFS, h1);
    rd8(COUNT_LOW_OFS, l);
    rd8(COUNT_HIGH_OFS, h2);
    if (h1 !== h2) begin
      rd8(COUNT_HIGH_OFS, h1);
      rd8(COUNT_LOW_OFS, l);
    end
    r = {h1, l};
  endtask

  // Clearing low first keeps a carry out of the high byte
  task automatic wr16(input logic [15:0] d);
    wr8(COUNT_LOW_OFS, 8'h00);
    wr8(COUNT_HIGH_OFS, d[15:8]);
    wr8(COUNT_LOW_OFS, d[7:0]);
  endtask

  // Timer mode: clocks between two increments
  task automatic period(input logic [7:0] ctl);
    logic [15:0] c;
    int n;
    wr8(CONTROL_OFS, ctl);
    for (int k = 0; k < 2; k++) begin
      c = count_value;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (count_value === c && n < 100);
    end
    chk(16'(n), 16'(4 << ctl[5:4]));
  endtask

  // Counter mode: one frame of edges from the far side, then compare
  task automatic ext_run(input logic [7:0] ctl, input logic slp, input logic [15:0] st);
    int e0, w0, inc, tot;
    logic wrap;
    wr8(CONTROL_OFS, 8'h00);
    use_crystal <= ctl[OSC_BIT];
    wr8(STATUS_OFS, 8'h01);
    wr16(st);
    wr8(CONTROL_OFS, ctl);
    repeat (2) @(posedge clock);
    chk(16'(lp_osc_enable), 16'(ctl[OSC_BIT]));
    chk(16'(timebase_valid), 16'(!ctl[SYNC_BIT]));
    repeat (20) @(posedge clock);
    e0 = edges;
    w0 = wakes;
    sleep_mode <= slp;
    run <= 1'b1;
    repeat (120) @(posedge clock);
    run <= 1'b0;
    repeat (12) @(posedge clock);
    sleep_mode <= 1'b0;
    inc = (ctl[SYNC_BIT] || !slp) ? ((edges - e0 - 1) >> ctl[5:4]) : 0;
    tot = st + inc;
    wrap = tot > 65535;
    chk(count_value, 16'(tot));
    chk(16'(overflow_flag), 16'(wrap));
    chk(16'(wakes - w0), 16'(wrap && slp));
    rd16(v);
    chk(v, 16'(tot));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    chk(16'(waitrequest), 16'h0001);
    rd8(CONTROL_OFS, q);
    chk(16'(q), 16'h0000);
    wr8(CONTROL_OFS, 8'hF0);
    rd8(CONTROL_OFS, q);
    chk(16'(q), 16'h0030);
    bus(1'b1, CONTROL_OFS, 8'h01, 4'h0, q);
    rd8(CONTROL_OFS, q);
    chk(16'(q), 16'h0030);
    rd8(4'h2, q);
    chk(16'(q), 16'h0000);
    wr16(16'h0000);
    period(8'h01);
    period(8'h15);
    period(8'h21);
    period(8'h35);
    wr8(CONTROL_OFS, 8'h00);
    repeat (4) @(posedge clock);
    v = count_value;
    repeat (40) @(posedge clock);
    chk(count_value, v);
    ext_run(8'h03, 1'b0, 16'h0000);
    ext_run(8'h0B, 1'b0, 16'hFFFE);
    ext_run(8'h17, 1'b0, 16'h0100);
    ext_run(8'h2F, 1'b0, 16'h0200);
    ext_run(8'h03, 1'b1, 16'h0000);
    ext_run(8'h07, 1'b1, 16'hFFFE);
    ext_run(8'h3B, 1'b0, 16'h0010);
    wr8(CONTROL_OFS, 8'h04);
    wr16(16'h1234);
    wr8(STATUS_OFS, 8'h01);
    special_event <= 1'b1;
    @(posedge clock);
    special_event <= 1'b0;
    repeat (2) @(posedge clock);
    chk(count_value, 16'h0000);
    chk(16'(overflow_flag), 16'h0000);
    wr8(CONTROL_OFS, 8'h06);
    wr16(16'h1234);
    special_event <= 1'b1;
    @(posedge clock);
    special_event <= 1'b0;
    repeat (2) @(posedge clock);
    chk(count_value, 16'h1234);
    wr8(CONTROL_OFS, 8'h00);
    special_event <= 1'b1;
    wr8(COUNT_HIGH_OFS, 8'h5A);
    special_event <= 1'b0;
    @(posedge clock);
    chk(count_value, 16'h5A00);
    wr16(16'hA5C3);
    wr8(CONTROL_OFS, 8'h08);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd16(v);
    chk(v, 16'hA5C3);
    rd8(CONTROL_OFS, q);
    chk(16'(q), 16'h0000);
    chk(16'(lp_osc_enable), 16'h0000);
    final_report();
  end

  // Hang guard: a run past this many clocks counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    $display("[FAIL] %0t run timed out", $time);
    final_report();
  end
endmodule
`default_nettype wire
